/* File: core/aabo_datapath.sv */
// Accumulator datapath: executes add, AND and bit operations, writes back
`timescale 1ns/10ps
module aabo_datapath (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire logic [2:0] i_op,
  input  wire logic [7:0] i_literal,
  input  wire logic [6:0] i_reg_addr,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_dest,
  input  wire logic [2:0] i_bit_sel,
  output logic      [7:0] o_accum,
  output logic            o_carry_flag,
  output logic            o_half_carry_flag,
  output logic            o_zero_flag,
  output logic            o_reg_we,
  output logic      [6:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  ////////////////////////////////////////////////////////////////////////////
  aabo_alu_if alu_bus ();

  aabo_alu u_alu (
    .alu (alu_bus)
  );

  aabo_pkg::aabo_op_t op;

  logic [7:0] accum;
  logic       carry_flag;
  logic       half_carry_flag;
  logic       zero_flag;
  logic       reg_we;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;

  logic [7:0] next_accum;
  logic       next_carry_flag;
  logic       next_half_carry_flag;
  logic       next_zero_flag;
  logic       next_reg_we;
  logic [6:0] next_reg_addr;
  logic [7:0] next_reg_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Unknown opcodes fall to no operation so nothing is written
  always_comb begin
    case (i_op)
      3'h1: begin
        op = aabo_pkg::AABO_OP_ADD_LIT;
      end
      3'h2: begin
        op = aabo_pkg::AABO_OP_AND_LIT;
      end
      3'h3: begin
        op = aabo_pkg::AABO_OP_ADD_REG;
      end
      3'h4: begin
        op = aabo_pkg::AABO_OP_AND_REG;
      end
      3'h5: begin
        op = aabo_pkg::AABO_OP_CLR_BIT;
      end
      3'h6: begin
        op = aabo_pkg::AABO_OP_SET_BIT;
      end
      default: begin
        op = aabo_pkg::AABO_OP_NONE;
      end
    endcase
  end

  always_comb begin
    alu_bus.op      = i_valid ? op : aabo_pkg::AABO_OP_NONE;
    alu_bus.a       = accum;
    alu_bus.bit_sel = i_bit_sel;
    // Literal ops take the immediate, all others the register operand
    if (op == aabo_pkg::AABO_OP_ADD_LIT ||
        op == aabo_pkg::AABO_OP_AND_LIT) begin
      alu_bus.b = i_literal;
    end else begin
      alu_bus.b = i_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded strobes, qualified by i_valid so an idle cycle changes nothing
  logic exec_add_lit;
  logic exec_and_lit;
  logic exec_add_reg;
  logic exec_and_reg;
  logic exec_clr_bit;
  logic exec_set_bit;
  logic upd_arith_flags;
  logic upd_zero_flag;
  logic wr_accum;
  logic wr_reg;

  always_comb begin
    exec_add_lit = 1'b0;
    exec_and_lit = 1'b0;
    exec_add_reg = 1'b0;
    exec_and_reg = 1'b0;
    exec_clr_bit = 1'b0;
    exec_set_bit = 1'b0;
    if (i_valid) begin
      case (op)
        aabo_pkg::AABO_OP_ADD_LIT: begin
          exec_add_lit = 1'b1;
        end
        aabo_pkg::AABO_OP_AND_LIT: begin
          exec_and_lit = 1'b1;
        end
        aabo_pkg::AABO_OP_ADD_REG: begin
          exec_add_reg = 1'b1;
        end
        aabo_pkg::AABO_OP_AND_REG: begin
          exec_and_reg = 1'b1;
        end
        aabo_pkg::AABO_OP_CLR_BIT: begin
          exec_clr_bit = 1'b1;
        end
        aabo_pkg::AABO_OP_SET_BIT: begin
          exec_set_bit = 1'b1;
        end
        default: begin
          // Opcodes 0 and 7 execute nothing
          exec_add_lit = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    // Only the adds produce carry and half carry; the ANDs keep them
    upd_arith_flags = exec_add_lit | exec_add_reg;
    // Adds and ANDs update zero; the bit operations alter no flag
    upd_zero_flag   = upd_arith_flags | exec_and_lit
                    | exec_and_reg;
    // The destination bit sends a register op's result to one place only
    wr_accum        = exec_add_lit | exec_and_lit
                    | ((exec_add_reg | exec_and_reg) & ~i_dest);
    wr_reg          = exec_clr_bit | exec_set_bit
                    | ((exec_add_reg | exec_and_reg) & i_dest);
  end

  ////////////////////////////////////////////////////////////////////////////
  // The ALU reads the registered accumulator, so back to back ops chain
  always_comb begin
    next_accum = accum;
    if (wr_accum) begin
      next_accum = alu_bus.result;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      accum <= aabo_pkg::ACC_RST;
    end else begin
      accum <= next_accum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags are plain outputs here, not bits of a status register
  always_comb begin
    next_carry_flag      = carry_flag;
    next_half_carry_flag = half_carry_flag;
    next_zero_flag       = zero_flag;
    if (upd_arith_flags) begin
      next_carry_flag      = alu_bus.carry;
      next_half_carry_flag = alu_bus.half_carry;
    end
    if (upd_zero_flag) begin
      next_zero_flag = alu_bus.zero;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      carry_flag      <= aabo_pkg::FLAG_RST;
      half_carry_flag <= aabo_pkg::FLAG_RST;
      zero_flag       <= aabo_pkg::FLAG_RST;
    end else begin
      carry_flag      <= next_carry_flag;
      half_carry_flag <= next_half_carry_flag;
      zero_flag       <= next_zero_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write port: address and data hold, the strobe lasts one cycle. There is
  // no forwarding, so the register file must hand a following op the value
  // written the cycle before.
  always_comb begin
    next_reg_we    = wr_reg;
    next_reg_addr  = reg_addr;
    next_reg_wdata = reg_wdata;
    if (wr_reg) begin
      next_reg_addr  = i_reg_addr;
      next_reg_wdata = alu_bus.result;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      reg_we    <= aabo_pkg::WE_RST;
      reg_addr  <= aabo_pkg::ADR_RST;
      reg_wdata <= aabo_pkg::WDATA_RST;
    end else begin
      reg_we    <= next_reg_we;
      reg_addr  <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_accum           = accum;
  assign o_carry_flag      = carry_flag;
  assign o_half_carry_flag = half_carry_flag;
  assign o_zero_flag       = zero_flag;
  assign o_reg_we          = reg_we;
  assign o_reg_addr        = reg_addr;
  assign o_reg_wdata       = reg_wdata;
endmodule

/* File: core/aabo_pkg.sv */
// Constants and types for the accumulator ALU and bit-operation datapath
package aabo_pkg;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned BIT_W   = 3;
  localparam logic [7:0]  ACC_RST = 8'h00;
  localparam logic [6:0]  ADR_RST = 7'h00;
  localparam logic [7:0]  WDATA_RST = 8'h00;
  localparam logic        FLAG_RST  = 1'b0;
  localparam logic        WE_RST    = 1'b0;
  localparam int unsigned HC_POS  = 4;

  typedef enum logic [2:0] {
    AABO_OP_NONE,
    AABO_OP_ADD_LIT,
    AABO_OP_AND_LIT,
    AABO_OP_ADD_REG,
    AABO_OP_AND_REG,
    AABO_OP_CLR_BIT,
    AABO_OP_SET_BIT
  } aabo_op_t;
endpackage

/* File: core/aabo_alu_if.sv */
// Interface carrying operands and results between the datapath and its ALU
`timescale 1ns/10ps
interface aabo_alu_if;
  aabo_pkg::aabo_op_t op;
  logic [7:0]         a;
  logic [7:0]         b;
  logic [2:0]         bit_sel;
  logic [7:0]         result;
  logic               carry;
  logic               half_carry;
  logic               zero;
  modport ctrl (output op, a, b, bit_sel,
                input  result, carry, half_carry, zero);
  modport alu  (input  op, a, b, bit_sel,
                output result, carry, half_carry, zero);
endinterface

/* File: core/aabo_alu.sv */
// Combinational ALU: add, AND, single-bit set and clear
`timescale 1ns/10ps
module aabo_alu (
  aabo_alu_if.alu alu
);
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic [7:0] bit_mask;

  always_comb begin
    low_sum  = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
    full_sum = {1'b0, alu.a} + {1'b0, alu.b};
    bit_mask = 8'h01 << alu.bit_sel;
    alu.result     = 8'h00;
    alu.carry      = 1'b0;
    alu.half_carry = 1'b0;
    case (alu.op)
      aabo_pkg::AABO_OP_ADD_LIT,
      aabo_pkg::AABO_OP_ADD_REG: begin
        alu.result     = full_sum[7:0];
        alu.carry      = full_sum[8];
        alu.half_carry = low_sum[aabo_pkg::HC_POS];
      end
      aabo_pkg::AABO_OP_AND_LIT,
      aabo_pkg::AABO_OP_AND_REG: begin
        alu.result = alu.a & alu.b;
      end
      aabo_pkg::AABO_OP_CLR_BIT: begin
        alu.result = alu.b & ~bit_mask;
      end
      aabo_pkg::AABO_OP_SET_BIT: begin
        alu.result = alu.b | bit_mask;
      end
      default: begin
        alu.result = 8'h00;
      end
    endcase
    alu.zero = (alu.result == 8'h00);
  end
endmodule

/* File: test/aabo_datapath_properties.sv */
// Port-level properties of the accumulator datapath
`timescale 1ns/10ps
module aabo_datapath_chk (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_valid,
  input wire logic [2:0] i_op,
  input wire logic [7:0] i_literal,
  input wire logic [6:0] i_reg_addr,
  input wire logic [7:0] i_reg_rdata,
  input wire logic       i_dest,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] o_accum,
  input wire logic       o_carry_flag,
  input wire logic       o_half_carry_flag,
  input wire logic       o_zero_flag,
  input wire logic       o_reg_we,
  input wire logic [6:0] o_reg_addr,
  input wire logic [7:0] o_reg_wdata
);
  ////////////////////////////////////////
  logic [7:0] opnd;
  logic [8:0] sum;
  logic       hc;
  logic       zs;
  assign opnd = (i_op == 3'h3) ? i_reg_rdata : i_literal;
  assign sum  = {1'b0, o_accum} + {1'b0, opnd};
  assign hc   = ({1'b0, o_accum[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
  assign zs   = (sum[7:0] == 8'h00);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence add_take; i_valid && (i_op == 3'h1 || i_op == 3'h3); endsequence
  sequence bit_take; i_valid && (i_op == 3'h5 || i_op == 3'h6); endsequence
  add_lit_a: assert property (i_valid && i_op == 3'h1
    |=> {o_carry_flag, o_accum} == $past(sum)) else $error("add literal");
  and_lit_a: assert property (i_valid && i_op == 3'h2
    |=> o_accum == ($past(o_accum) & $past(i_literal))
    && $stable(o_carry_flag)) else $error("and literal");
  and_reg_a: assert property (i_valid && i_op == 3'h4 && !i_dest
    |=> o_accum == ($past(o_accum) & $past(i_reg_rdata))
    && $stable(o_half_carry_flag)) else $error("and register");
  add_reg_a: assert property (i_valid && i_op == 3'h3 && i_dest
    |=> {o_carry_flag, o_reg_wdata} == $past(sum) && $stable(o_accum))
    else $error("add register");
  dest_route_a: assert property (i_valid && i_op inside {3'h3, 3'h4}
    |=> o_reg_we == $past(i_dest)) else $error("destination routing");
  flag_calc_a: assert property (add_take |=>
    o_half_carry_flag == $past(hc) && o_zero_flag == $past(zs))
    else $error("add flags");
  clr_bit_a: assert property (i_valid && i_op == 3'h5 |=> o_reg_we
    && o_reg_wdata == ($past(i_reg_rdata) & ~(8'h01 << $past(i_bit_sel))))
    else $error("bit clear");
  set_bit_a: assert property (i_valid && i_op == 3'h6 |=> o_reg_we
    && o_reg_wdata == ($past(i_reg_rdata) | (8'h01 << $past(i_bit_sel))))
    else $error("bit set");
  bit_flags_a: assert property (bit_take |=> o_reg_addr ==
    $past(i_reg_addr) && $stable({o_carry_flag, o_half_carry_flag,
    o_zero_flag})) else $error("bit op flags");
endmodule
bind aabo_datapath aabo_datapath_chk u_chk (.*);

/* File: test/testbench.sv */
// Self-checking bench for the accumulator datapath
`timescale 1ns/10ps
module testbench;
  logic       i_core_clk, i_rst, i_valid, i_dest, o_reg_we;
  logic       o_carry_flag, o_half_carry_flag, o_zero_flag;
  logic [2:0] i_op, i_bit_sel;
  logic [6:0] i_reg_addr, o_reg_addr;
  logic [7:0] i_literal, i_reg_rdata, o_accum, o_reg_wdata;
  int         err_count = 0;
  int         num_checks = 0;
  logic [7:0] acc = 8'h00;
  logic       c = 1'b0, h = 1'b0, z = 1'b0;
  logic [6:0] la = 7'h00;
  logic [7:0] lw = 8'h00;
  logic [7:0] seen_flags;
  assign seen_flags = {5'h00, o_carry_flag, o_half_carry_flag, o_zero_flag};
  aabo_datapath u_aabo_datapath (.*);
  ////////////////////////////////////////
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Operand goes to the port the op uses; the other port gets its inverse
  task automatic do_op(input logic vld, input logic [2:0] op,
                       input logic [7:0] v, input logic d, input logic [2:0] b);
    logic [8:0] s;
    logic [7:0] r;
    logic       we;
    i_valid = vld;
    i_op = op;
    i_literal = (op < 3'h3) ? v : ~v;
    i_reg_rdata = (op < 3'h3) ? ~v : v;
    i_reg_addr = v[6:0];
    i_dest = d;
    i_bit_sel = b;
    @(posedge i_core_clk);
    #1;
    s = (op == 3'h1 || op == 3'h3) ? {1'b0, acc} + {1'b0, v} : {1'b0, acc & v};
    r = (op == 3'h5) ? v & ~(8'h01 << b) : s[7:0];
    if (op == 3'h6) r = v | (8'h01 << b);
    we = vld && (op inside {3'h5, 3'h6} || (d && op inside {3'h3, 3'h4}));
    if (vld && op inside {3'h1, 3'h3}) begin
      c = s[8];
      h = ({1'b0, acc[3:0]} + {1'b0, v[3:0]}) > 5'h0f;
    end
    if (vld && op >= 3'h1 && op <= 3'h4) z = (r == 8'h00);
    if (vld && (op inside {3'h1, 3'h2} || (!d && op inside {3'h3, 3'h4})))
      acc = r;
    chk(o_accum, acc);
    chk(seen_flags, 8'({c, h, z}));
    chk(8'(o_reg_we), 8'(we));
    // Address and data hold their last values while no write happens
    if (we) begin
      la = v[6:0];
      lw = r;
    end
    chk(8'(o_reg_addr), 8'(la));
    chk(o_reg_wdata, lw);
  endtask
  task automatic t_lit();
    do_op(1, 3'h1, 8'h0f, 0, 0);
    do_op(1, 3'h1, 8'h01, 0, 0);
    do_op(1, 3'h1, 8'hf0, 0, 0);
    do_op(1, 3'h1, 8'hff, 0, 0);
    do_op(1, 3'h2, 8'h0f, 0, 0);
    do_op(1, 3'h2, 8'hf0, 0, 0);
  endtask
  task automatic t_reg();
    do_op(1, 3'h3, 8'h81, 1, 0);
    do_op(1, 3'h3, 8'h81, 0, 0);
    do_op(1, 3'h4, 8'hff, 1, 0);
    do_op(1, 3'h4, 8'h00, 0, 0);
  endtask
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      do_op(1, 3'h5, 8'hff, 0, 3'(b));
      do_op(1, 3'h6, 8'h00, 1, 3'(b));
    end
  endtask
  // Disabled strobe and unused opcodes must leave everything alone
  task automatic t_idle();
    do_op(0, 3'h1, 8'h55, 1, 0);
    do_op(1, 3'h7, 8'h55, 1, 0);
    do_op(1, 3'h0, 8'h55, 1, 0);
  endtask
  // Reset in mid-run puts every output back to its idle value
  task automatic t_rst();
    do_op(1, 3'h1, 8'h80, 1, 0);
    i_rst = 1'b1;
    @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    acc = 8'h00;
    c = 1'b0;
    h = 1'b0;
    z = 1'b0;
    la = 7'h00;
    lw = 8'h00;
    chk(o_accum, acc);
    chk(seen_flags, 8'h00);
    chk(8'(o_reg_we), 8'h00);
    chk(8'(o_reg_addr), 8'h00);
    chk(o_reg_wdata, 8'h00);
    do_op(1, 3'h1, 8'h0f, 0, 0);
  endtask
  initial begin
    i_rst = 1'b1;
    i_valid = 1'b0;
    i_op = 3'h0;
    i_literal = 8'h00;
    i_reg_addr = 7'h00;
    i_reg_rdata = 8'h00;
    i_dest = 1'b0;
    i_bit_sel = 3'h0;
    repeat (2) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    chk(o_accum, 8'h00);
    chk(seen_flags, 8'h00);
    chk(8'(o_reg_we), 8'h00);
    t_lit();
    t_reg();
    t_bits();
    t_idle();
    t_rst();
    end_sim();
  end
  initial begin
    #2000;
    err_count++;
    end_sim();
  end
endmodule
